/* File: logic/status_reporting_regs.svh */
// Bit positions, reset values and sizes of the status reporting block
`ifndef STATUS_REPORTING_REGS_SVH
`define STATUS_REPORTING_REGS_SVH

// Status byte fields
`define SB_RID_BIT      7
`define SB_RQS_BIT      6
`define SB_ESB_BIT      5
`define SB_MAV_BIT      4
`define SB_EAV_BIT      3
`define SB_INSTRUMENT_CHANGE_SUMMARY_BIT     2
`define SB_LIVE_MASK    8'hBC
`define SB_RESET        8'h00
`define SRE_RESET       8'h00

// Event latch fields
`define EV_PON_BIT      7
`define EV_CME_BIT      5
`define EV_EXE_BIT      4
`define EV_DDE_BIT      3
`define EV_QYE_BIT      2
`define EV_OPC_BIT      0
`define EV_LIVE_MASK    16'h00BD
`define EV_LATCH_RESET  16'h0080
`define EV_MASK_RESET   16'h0000

// Error queue and poll reply sizes
`define ERRQ_DEPTH      16
`define ERRQ_AW         4
`define POLL_STR_LEN    4
`define POLL_CNT_W      3
`endif

/* File: logic/status_reporting_pkg.sv */
// Types shared by the status reporting block
package status_reporting_pkg;
    typedef enum logic [3:0] {
        CMD_NONE      = 4'h0,
        CMD_STB_QUERY = 4'h1,
        CMD_SRE_WRITE = 4'h2,
        CMD_SRE_QUERY = 4'h3,
        CMD_ESR_QUERY = 4'h4,
        CMD_ESE_WRITE = 4'h5,
        CMD_ESE_QUERY = 4'h6,
        CMD_CLS       = 4'h7,
        CMD_ERR_QUERY = 4'h8
    } remote_cmd_e;

    typedef struct packed {
        logic        valid;
        remote_cmd_e code;
        logic [15:0] data;
    } remote_req_s;

    typedef struct packed {
        logic       valid;
        logic [7:0] data;
    } tx_char_s;

    typedef enum logic [1:0] {
        TX_IDLE   = 2'b00,
        TX_STRING = 2'b01,
        TX_STATUS = 2'b10
    } tx_state_e;
endpackage

/* File: logic/error_queue.sv */
// Sixteen-entry first-in first-out store of error codes
`timescale 1ns/100ps
`default_nettype none
`include "status_reporting_regs.svh"
module error_queue (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    // Queue control
    input  wire logic        push_in,
    input  wire logic [15:0] code_in,
    input  wire logic        pop_in,
    input  wire logic        flush_in,
    // Queue status
    output logic [15:0]      head_out,
    output logic             pending_out
);
    import status_reporting_pkg::*;

    typedef struct packed {
        logic [`ERRQ_AW-1:0] rd_ptr;
        logic [`ERRQ_AW-1:0] wr_ptr;
        logic [`ERRQ_AW:0]   count;
    } errq_state_s;

    logic [15:0] mem_ff [`ERRQ_DEPTH];
    errq_state_s st_ff;
    errq_state_s nxt_st;
    logic        do_push;
    logic        do_pop;

    // A full queue drops the newest code; the oldest ones are kept
    assign do_push = push_in && (st_ff.count != 5'(`ERRQ_DEPTH)) && !flush_in;
    assign do_pop  = pop_in && (st_ff.count != 5'h00) && !flush_in;

    always_comb begin
        nxt_st = st_ff;
        if (flush_in) begin
            nxt_st = '0;
        end else begin
            if (do_push) nxt_st.wr_ptr = st_ff.wr_ptr + 4'h1;
            if (do_pop) nxt_st.rd_ptr = st_ff.rd_ptr + 4'h1;
            nxt_st.count = st_ff.count + 5'(do_push) - 5'(do_pop);
        end
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (do_push) mem_ff[st_ff.wr_ptr] <= code_in;
    end

    assign head_out    = (st_ff.count == 5'h00) ? 16'h0000 : mem_ff[st_ff.rd_ptr];
    assign pending_out = (st_ff.count != 5'h00);
endmodule
`default_nettype wire

/* File: logic/poll_reply_tx.sv */
// Sends the poll reply string and then a captured status byte
`timescale 1ns/100ps
`default_nettype none
`include "status_reporting_regs.svh"
module poll_reply_tx (
    // Clock and reset
    input  wire logic                         ref_clk_in,
    input  wire logic                         reset_in,
    // Trigger
    input  wire logic                         start_in,
    input  wire logic [7:0]                   status_in,
    input  wire logic [`POLL_STR_LEN*8-1:0]   string_in,
    // Character stream
    output status_reporting_pkg::tx_char_s    tx_out,
    input  wire logic                         tx_ready_in,
    output logic                              busy_out
);
    import status_reporting_pkg::*;

    typedef struct packed {
        tx_state_e             state;
        logic [`POLL_CNT_W-1:0] idx;
        logic [7:0]            status;
    } tx_seq_s;

    tx_seq_s st_ff;
    tx_seq_s nxt_st;

    always_comb begin
        nxt_st = st_ff;
        case (st_ff.state)
            TX_IDLE: begin
                if (start_in) begin
                    nxt_st.state  = TX_STRING;
                    nxt_st.idx    = '0;
                    nxt_st.status = status_in;
                end
            end
            TX_STRING: begin
                if (tx_ready_in) begin
                    nxt_st.idx = st_ff.idx + 3'h1;
                    if (st_ff.idx == 3'(`POLL_STR_LEN - 1)) nxt_st.state = TX_STATUS;
                end
            end
            TX_STATUS: begin
                if (tx_ready_in) nxt_st.state = TX_IDLE;
            end
            default: nxt_st.state = TX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_ff <= '{state: TX_IDLE, idx: '0, status: 8'h00};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // First string character sits in the top byte
    always_comb begin
        tx_out.valid = (st_ff.state == TX_STRING) || (st_ff.state == TX_STATUS);
        tx_out.data  = st_ff.status;
        if (st_ff.state == TX_STRING) begin
            tx_out.data = string_in[(`POLL_STR_LEN - 1 - int'(st_ff.idx)) * 8 +: 8];
        end
    end

    assign busy_out = (st_ff.state != TX_IDLE);
endmodule
`default_nettype wire

/* File: logic/ieee488_status_reporting.sv */
// Status byte, service request, event latch and error queue logic
//
// Functional notes
// - Status byte bits 1 and 0 read zero
// - Status byte cleared at power-up
// - Serial poll returns the status byte
// - Bit 7 shows remote interface awaiting input
// - Enabled summary rising edge on bits 5 to 2 sets request latch
// - Bit 6 query level: any enabled summary
// - Status query returns summary level remotely
// - Bit 5 set by enabled event latch bits
// - Bit 4 set while output buffer holds data
// - Bit 3 set while error queue non-empty
// - Error codes kept in sixteen-entry queue
// - Bit 2 set by instrument change input, no mask
// - SRQ asserted while request latch is set
// - Poll, clear or summary drop clears request
// - Summary level drops only when all disabled
// - Service mask cleared at reset, one enables
// - Event latch sixteen bits, dead bits zero
// - Event latch cleared on every read
// - Event latch holds 128 after power-on
// - Event mask gates summary, cleared at reset
// - Event summary holds until read, clear or event mask write
// - Control-P sends reply string, status byte
// - Event latch bit placement fixed
// - Event mask read is non-destructive, 16 bits
`timescale 1ns/100ps
`default_nettype none
`include "status_reporting_regs.svh"
module ieee488_status_reporting (
    // Clock and reset
    input  wire logic                            ref_clk_in,
    input  wire logic                            reset_in,
    // Remote command port
    input  wire status_reporting_pkg::remote_req_s req_in,
    output logic                                 reply_valid_out,
    output logic [15:0]                          reply_data_out,
    // IEEE-488 serial poll and service request
    input  wire logic                            spoll_in,
    output logic                                 spoll_valid_out,
    output logic [7:0]                           spoll_data_out,
    output logic                                 srq_out,
    // Instrument conditions
    input  wire logic                            remote_idle_in,
    input  wire logic                            output_pending_in,
    input  wire logic                            instrument_change_in,
    // Event pulses, one bit per event latch position
    input  wire logic                            power_cycle_flag_in,
    input  wire logic                            command_syntax_error_in,
    input  wire logic                            run_fault_flag_in,
    input  wire logic                            device_specific_fault_in,
    input  wire logic                            query_fault_flag_in,
    input  wire logic                            operation_complete_flag_in,
    // Error queue filling side
    input  wire logic                            err_push_in,
    input  wire logic [15:0]                     err_code_in,
    // Serial, USB or Ethernet poll reply stream
    input  wire logic                            ctrl_p_in,
    input  wire logic [`POLL_STR_LEN*8-1:0]      poll_reply_string_in,
    output status_reporting_pkg::tx_char_s       tx_out,
    input  wire logic                            tx_ready_in,
    // Register views
    output logic [7:0]                           status_byte_out,
    output logic [7:0]                           service_mask_out,
    output logic [15:0]                          event_latch_reg_out,
    output logic [15:0]                          event_mask_out
);
    import status_reporting_pkg::*;

    ////////////////////////////////
    // State

    typedef struct packed {
        logic [7:0]  status_byte;
        logic        service_request_latch;
        logic [3:0]  prev_enabled;
        logic [7:0]  service_mask;
        logic [15:0] event_latch_reg;
        logic [15:0] event_mask;
        logic        reply_valid;
        logic [15:0] reply_data;
        logic        spoll_valid;
        logic [7:0]  spoll_data;
    } status_state_s;

    status_state_s st_ff;
    status_state_s nxt_st;

    ////////////////////////////////
    // Decoding helpers

    // Strobe for one command code, used for the clear, read and mask write decodes
    function automatic logic cmd_hit(input remote_req_s req, input remote_cmd_e code);
        cmd_hit = req.valid && (req.code == code);
    endfunction

    // Gate a summary byte by the service mask; bits 6, 1 and 0 never count
    function automatic logic [7:0] enabled_bits(input logic [7:0] flags,
                                                input logic [7:0] mask);
        enabled_bits = flags & mask & `SB_LIVE_MASK;
    endfunction

    ////////////////////////////////
    // Command strobes

    logic cls_cmd;
    logic esr_read;
    logic err_read;
    logic poll_any;
    logic tx_busy;
    logic poll_start;

    assign cls_cmd  = cmd_hit(req_in, CMD_CLS);
    assign esr_read = cmd_hit(req_in, CMD_ESR_QUERY);
    assign err_read = cmd_hit(req_in, CMD_ERR_QUERY);

    // A control-P arriving while a reply is still going out is dropped
    assign poll_start = ctrl_p_in && !tx_busy;
    assign poll_any   = spoll_in || poll_start;

    ////////////////////////////////
    // Error queue

    logic [15:0] err_head;
    logic        err_pending;

    error_queue u_error_queue (
        .ref_clk_in  (ref_clk_in),
        .reset_in    (reset_in),
        .push_in     (err_push_in),
        .code_in     (err_code_in),
        .pop_in      (err_read),
        .flush_in    (cls_cmd),
        .head_out    (err_head),
        .pending_out (err_pending)
    );

    ////////////////////////////////
    // Event latch inputs

    logic [15:0] event_set;

    always_comb begin
        event_set                 = 16'h0000;
        event_set[`EV_PON_BIT]    = power_cycle_flag_in;
        event_set[`EV_CME_BIT]    = command_syntax_error_in;
        event_set[`EV_EXE_BIT]    = run_fault_flag_in;
        event_set[`EV_DDE_BIT]    = device_specific_fault_in;
        event_set[`EV_QYE_BIT]    = query_fault_flag_in;
        event_set[`EV_OPC_BIT]    = operation_complete_flag_in;
    end

    ////////////////////////////////
    // Summary flags

    logic [7:0] live_flags;
    logic [7:0] enabled_now;
    logic [3:0] enabled_sum;
    logic [3:0] rising;
    logic       summary_status_level;
    logic       event_summary_flag;

    // Summary stays up as long as the latch holds an enabled bit
    assign event_summary_flag = |(st_ff.event_latch_reg & st_ff.event_mask
                                  & `EV_LIVE_MASK);

    always_comb begin
        live_flags               = 8'h00;
        live_flags[`SB_RID_BIT]  = remote_idle_in;
        live_flags[`SB_ESB_BIT]  = event_summary_flag;
        live_flags[`SB_MAV_BIT]  = output_pending_in;
        live_flags[`SB_EAV_BIT]  = err_pending;
        live_flags[`SB_INSTRUMENT_CHANGE_SUMMARY_BIT] = instrument_change_in;
    end

    assign enabled_now = enabled_bits(live_flags, st_ff.service_mask);

    // Remote idle is part of the level but raises no request on its own
    assign summary_status_level = |enabled_now;
    assign enabled_sum = enabled_now[`SB_ESB_BIT:`SB_INSTRUMENT_CHANGE_SUMMARY_BIT];
    assign rising      = enabled_sum & ~st_ff.prev_enabled;

    ////////////////////////////////
    // Next state

    logic [7:0] poll_byte;

    // Serial poll carries the request latch in bit 6
    always_comb begin
        poll_byte              = st_ff.status_byte;
        poll_byte[`SB_RQS_BIT] = st_ff.service_request_latch;
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.prev_enabled = enabled_sum;

        // Request latch: a fresh edge wins over every clear
        if (|rising) begin
            nxt_st.service_request_latch = 1'b1;
        end else if (poll_any || cls_cmd || !summary_status_level) begin
            nxt_st.service_request_latch = 1'b0;
        end

        // Status byte copy tracks the flags each cycle
        nxt_st.status_byte = live_flags & `SB_LIVE_MASK;
        nxt_st.status_byte[`SB_RQS_BIT] = summary_status_level;

        // Event latch: clear on read or clear, new events always land
        if (esr_read || cls_cmd) begin
            nxt_st.event_latch_reg = event_set & `EV_LIVE_MASK;
        end else begin
            nxt_st.event_latch_reg = (st_ff.event_latch_reg | event_set)
                                     & `EV_LIVE_MASK;
        end

        // Mask writes
        if (cmd_hit(req_in, CMD_SRE_WRITE)) begin
            nxt_st.service_mask = req_in.data[7:0] & `SB_LIVE_MASK;
        end
        if (cmd_hit(req_in, CMD_ESE_WRITE)) begin
            nxt_st.event_mask = req_in.data;
        end

        // Query replies, one cycle after the command
        nxt_st.reply_valid = 1'b0;
        if (req_in.valid) begin
            case (req_in.code)
                CMD_STB_QUERY: begin
                    nxt_st.reply_valid = 1'b1;
                    nxt_st.reply_data  = {8'h00, st_ff.status_byte};
                end
                CMD_SRE_QUERY: begin
                    nxt_st.reply_valid = 1'b1;
                    nxt_st.reply_data  = {8'h00, st_ff.service_mask};
                end
                CMD_ESR_QUERY: begin
                    nxt_st.reply_valid = 1'b1;
                    nxt_st.reply_data  = st_ff.event_latch_reg;
                end
                CMD_ESE_QUERY: begin
                    nxt_st.reply_valid = 1'b1;
                    nxt_st.reply_data  = st_ff.event_mask;
                end
                CMD_ERR_QUERY: begin
                    nxt_st.reply_valid = 1'b1;
                    nxt_st.reply_data  = err_head;
                end
                default: begin
                    nxt_st.reply_valid = 1'b0;
                end
            endcase
        end

        // Serial poll answer
        nxt_st.spoll_valid = spoll_in;
        if (spoll_in) begin
            nxt_st.spoll_data = poll_byte;
        end
    end

    ////////////////////////////////
    // Registers

    always_ff @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_ff.status_byte           <= `SB_RESET;
            st_ff.service_request_latch <= 1'b0;
            st_ff.prev_enabled          <= 4'h0;
            st_ff.service_mask          <= `SRE_RESET;
            st_ff.event_latch_reg       <= `EV_LATCH_RESET;
            st_ff.event_mask            <= `EV_MASK_RESET;
            st_ff.reply_valid           <= 1'b0;
            st_ff.reply_data            <= 16'h0000;
            st_ff.spoll_valid           <= 1'b0;
            st_ff.spoll_data            <= 8'h00;
        end else begin
            st_ff <= nxt_st;
        end
    end

    ////////////////////////////////
    // Poll reply over the character link

    poll_reply_tx u_poll_reply_tx (
        .ref_clk_in  (ref_clk_in),
        .reset_in    (reset_in),
        .start_in    (poll_start),
        .status_in   (poll_byte),
        .string_in   (poll_reply_string_in),
        .tx_out      (tx_out),
        .tx_ready_in (tx_ready_in),
        .busy_out    (tx_busy)
    );

    ////////////////////////////////
    // Outputs

    assign srq_out             = st_ff.service_request_latch;
    assign reply_valid_out     = st_ff.reply_valid;
    assign reply_data_out      = st_ff.reply_data;
    assign spoll_valid_out     = st_ff.spoll_valid;
    assign spoll_data_out      = st_ff.spoll_data;
    assign status_byte_out     = st_ff.status_byte;
    assign service_mask_out    = st_ff.service_mask;
    assign event_latch_reg_out = st_ff.event_latch_reg;
    assign event_mask_out      = st_ff.event_mask;
endmodule
`default_nettype wire

/* File: verification/status_reporting_props.sv */
// Port checker for the status reporting block, bound to its top
`timescale 1ns/100ps
`default_nettype none
module status_reporting_props (
    // Clock and reset
    input wire logic                              ref_clk_in,
    input wire logic                              reset_in,
    // Command and poll ports
    input wire status_reporting_pkg::remote_req_s req_in,
    input wire logic                              reply_valid_out,
    input wire logic [15:0]                       reply_data_out,
    input wire logic                              spoll_in,
    input wire logic                              spoll_valid_out,
    input wire logic [7:0]                        spoll_data_out,
    input wire logic                              srq_out,
    // Register views
    input wire logic [7:0]                        status_byte_out,
    input wire logic [7:0]                        service_mask_out,
    input wire logic [15:0]                       event_latch_reg_out,
    input wire logic [15:0]                       event_mask_out
);
    import status_reporting_pkg::*;
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    wire logic esr_rd = req_in.valid && req_in.code == CMD_ESR_QUERY;
    ////////////////////////////////
    // A poll is only judged when no new rise lands beside it, since set wins
    sequence s_poll;
        spoll_in && !req_in.valid;
    endsequence
    sequence s_poll_quiet;
        s_poll ##1 $stable(status_byte_out);
    endsequence
    a_low_bits_zero: assert property (status_byte_out[1:0] == 2'h0)
        else $error("status byte low bits set");
    a_poll_answer: assert property (spoll_in |=> spoll_valid_out)
        else $error("serial poll not answered");
    a_dead_bits: assert property ((event_latch_reg_out & 16'hFF42) == 16'h0000)
        else $error("event latch dead bit set");
    a_esr_read_clears: assert property (esr_rd |=> reply_valid_out &&
        reply_data_out == $past(event_latch_reg_out) &&
        (event_latch_reg_out & $past(event_latch_reg_out)) == 16'h0000)
        else $error("event latch read wrong");
    a_mask_read_kept: assert property (req_in.valid && req_in.code == CMD_ESE_QUERY |=>
        $stable(event_mask_out) && reply_data_out == event_mask_out)
        else $error("event mask read wrong");
    a_mask_write: assert property (req_in.valid && req_in.code == CMD_SRE_WRITE |=>
        service_mask_out == ($past(req_in.data[7:0]) & 8'hBC))
        else $error("service mask write wrong");
    a_poll_clears: assert property (s_poll_quiet |-> !srq_out)
        else $error("poll left request set");
    a_rise_requests: assert property ($rose(status_byte_out[5]) && service_mask_out[5] &&
        $stable(service_mask_out) |-> srq_out)
        else $error("enabled rise gave no request");
    a_summary_level: assert property ($stable(service_mask_out) |-> status_byte_out[6] ==
        |(status_byte_out[7:2] & service_mask_out[7:2] & 6'h2F))
        else $error("summary level wrong");
endmodule
bind ieee488_status_reporting status_reporting_props u_props (
    .ref_clk_in(ref_clk_in), .reset_in(reset_in), .req_in(req_in),
    .reply_valid_out(reply_valid_out), .reply_data_out(reply_data_out),
    .spoll_in(spoll_in), .spoll_valid_out(spoll_valid_out),
    .spoll_data_out(spoll_data_out), .srq_out(srq_out),
    .status_byte_out(status_byte_out), .service_mask_out(service_mask_out),
    .event_latch_reg_out(event_latch_reg_out), .event_mask_out(event_mask_out));
`default_nettype wire

/* File: verification/remote_host.sv */
// Remote host taking the poll reply stream, promptly or with stalls
`timescale 1ns/100ps
`default_nettype none
module remote_host (
    // Clock and reset
    input wire logic                           ref_clk_in,
    input wire logic                           reset_in,
    // Character stream
    input wire status_reporting_pkg::tx_char_s tx_in,
    input wire logic                           slow_in,
    output logic                               ready_out
);
    import status_reporting_pkg::*;
    logic [7:0] rx_q [$];
    logic       phase_ff;
    // A slow host accepts every other cycle, so the sender must hold
    assign ready_out = !slow_in || phase_ff;
    always @(posedge ref_clk_in or posedge reset_in) begin
        if (reset_in) begin
            phase_ff <= 1'b0;
        end else begin
            phase_ff <= !phase_ff;
            if (tx_in.valid && ready_out) begin
                rx_q.push_back(tx_in.data);
            end
        end
    end
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the status reporting block
`timescale 1ns/100ps
`default_nettype none
module tb;
    import status_reporting_pkg::*;
    typedef struct {
        remote_cmd_e code;
        logic [15:0] data;
        logic        rep;
        logic [15:0] exp;
    } row_s;
    logic        ref_clk_in = 1'b0;
    logic        reset_in, spoll, err_push, ctrl_p, slow, ready, rv, sv, srq;
    remote_req_s req;
    tx_char_s    tx;
    logic [2:0]  lv;
    logic [5:0]  ev;
    logic [15:0] err_code, rd, el, em;
    logic [31:0] str;
    logic [7:0]  sd, sb, sm;
    int          errors, tests_run, n;
    int          pos [6] = '{0, 2, 3, 4, 5, 7};
    logic [7:0]  lvb [3] = '{8'h80, 8'h10, 8'h04};
    row_s        rows [11] = '{
        '{CMD_ESR_QUERY, 16'h0000, 1'b1, 16'h0080},
        '{CMD_ESR_QUERY, 16'h0000, 1'b1, 16'h0000},
        '{CMD_SRE_QUERY, 16'h0000, 1'b1, 16'h0000},
        '{CMD_ESE_QUERY, 16'h0000, 1'b1, 16'h0000},
        '{CMD_STB_QUERY, 16'h0000, 1'b1, 16'h0000},
        '{CMD_ERR_QUERY, 16'h0000, 1'b1, 16'h0000},
        '{CMD_SRE_WRITE, 16'hFFFF, 1'b0, 16'h0000},
        '{CMD_SRE_QUERY, 16'h0000, 1'b1, 16'h00BC},
        '{CMD_ESE_WRITE, 16'h00FF, 1'b0, 16'h0000},
        '{CMD_ESE_QUERY, 16'h0000, 1'b1, 16'h00FF},
        '{CMD_NONE, 16'h0000, 1'b0, 16'h0000}};
    always #12.5 ref_clk_in = ~ref_clk_in;
    ieee488_status_reporting u_dut (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .req_in(req),
        .reply_valid_out(rv), .reply_data_out(rd), .spoll_in(spoll),
        .spoll_valid_out(sv), .spoll_data_out(sd), .srq_out(srq),
        .remote_idle_in(lv[0]), .output_pending_in(lv[1]), .instrument_change_in(lv[2]),
        .power_cycle_flag_in(ev[5]), .command_syntax_error_in(ev[4]),
        .run_fault_flag_in(ev[3]), .device_specific_fault_in(ev[2]),
        .query_fault_flag_in(ev[1]), .operation_complete_flag_in(ev[0]),
        .err_push_in(err_push), .err_code_in(err_code), .ctrl_p_in(ctrl_p),
        .poll_reply_string_in(str), .tx_out(tx), .tx_ready_in(ready),
        .status_byte_out(sb), .service_mask_out(sm),
        .event_latch_reg_out(el), .event_mask_out(em));
    remote_host u_host (
        .ref_clk_in(ref_clk_in), .reset_in(reset_in), .tx_in(tx),
        .slow_in(slow), .ready_out(ready));
    ////////////////////////////////
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge ref_clk_in);
        #1;
    endtask
    task automatic cmd(input remote_cmd_e c, input logic [15:0] d, input logic r,
                       input logic [15:0] e);
        @(posedge ref_clk_in);
        req <= '{1'b1, c, d};
        @(posedge ref_clk_in);
        req <= '0;
        #1;
        chk(rv, r);
        if (r) begin
            chk(rd, e);
        end
    endtask
    task automatic pulse(input logic [5:0] v);
        @(posedge ref_clk_in);
        ev <= v;
        @(posedge ref_clk_in);
        ev <= '0;
        tick(2);
    endtask
    task automatic close_out;
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////
    initial begin
        reset_in = 1'b1;
        req = '0;
        {spoll, err_push, ctrl_p, slow, lv, ev, err_code} = '0;
        str = 32'h0A51520A;
        repeat (3) @(posedge ref_clk_in);
        reset_in <= 1'b0;
        foreach (rows[i]) cmd(rows[i].code, rows[i].data, rows[i].rep, rows[i].exp);
        pulse(6'h10);
        chk(srq, 1'b1);
        chk(sb, 8'h60);
        cmd(CMD_STB_QUERY, 16'h0000, 1'b1, 16'h0060);
        @(posedge ref_clk_in);
        spoll <= 1'b1;
        @(posedge ref_clk_in);
        spoll <= 1'b0;
        #1;
        chk(sv, 1'b1);
        chk(sd, 8'h60);
        chk(srq, 1'b0);
        chk(sb, 8'h60);
        cmd(CMD_ESR_QUERY, 16'h0000, 1'b1, 16'h0020);
        tick(1);
        chk(sb, 8'h00);
        for (int i = 0; i < 6; i++) begin
            pulse(6'h01 << i);
            cmd(CMD_ESR_QUERY, 16'h0000, 1'b1, 16'h0001 << pos[i]);
        end
        // A new event beside a read must survive the clear
        @(posedge ref_clk_in);
        ev <= 6'h10;
        req <= '{1'b1, CMD_ESR_QUERY, 16'h0000};
        @(posedge ref_clk_in);
        ev <= '0;
        req <= '0;
        tick(2);
        chk(el, 16'h0020);
        cmd(CMD_CLS, 16'h0000, 1'b0, 16'h0000);
        tick(1);
        chk(srq, 1'b0);
        for (int i = 0; i < 3; i++) begin
            @(posedge ref_clk_in);
            lv <= 3'h1 << i;
            tick(2);
            chk(sb, lvb[i] | 8'h40);
            chk(srq, i != 0);
            @(posedge ref_clk_in);
            lv <= '0;
            tick(2);
            chk(sb, 8'h00);
        end
        for (int i = 1; i <= 17; i++) begin
            @(posedge ref_clk_in);
            err_push <= 1'b1;
            err_code <= 16'(i);
        end
        @(posedge ref_clk_in);
        err_push <= 1'b0;
        tick(2);
        chk(sb, 8'h48);
        for (int i = 1; i <= 17; i++) begin
            cmd(CMD_ERR_QUERY, 16'h0000, 1'b1, (i < 17) ? 16'(i) : 16'h0000);
        end
        tick(1);
        chk(sb, 8'h00);
        pulse(6'h10);
        @(posedge ref_clk_in);
        slow <= 1'b1;
        ctrl_p <= 1'b1;
        @(posedge ref_clk_in);
        ctrl_p <= 1'b0;
        for (n = 0; n < 40 && u_host.rx_q.size() < 5; n++) begin
            tick(1);
        end
        if (n == 40) begin
            errors++;
            close_out();
        end
        for (int i = 0; i < 4; i++) begin
            chk(u_host.rx_q[i], str[31 - 8 * i -: 8]);
        end
        chk(u_host.rx_q[4], 8'h60);
        @(posedge ref_clk_in);
        reset_in <= 1'b1;
        tick(2);
        chk(sb, 8'h00);
        chk(el, 16'h0080);
        chk(sm, 8'h00);
        chk(em, 16'h0000);
        @(posedge ref_clk_in);
        reset_in <= 1'b0;
        cmd(CMD_ESR_QUERY, 16'h0000, 1'b1, 16'h0080);
        close_out();
    end
endmodule
`default_nettype wire
